// ---- design/msl_pkg.sv ----
// Package of constants and carrier types for the serial host link
package msl_pkg;
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned BAUD          = 9600;
    localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYC      = BIT_CYC / 2;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned BREAK_BITS    = 20;
    localparam int unsigned BREAK_CYC     = BIT_CYC * BREAK_BITS;
    localparam int unsigned FIFO_DEPTH    = 4;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;
    localparam logic [23:0] BRK_ZERO      = 24'h000000;
    localparam logic [3:0]  BIT_ZERO      = 4'h0;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [1:0]  SYNC_IDLE     = 2'h0;

    typedef enum logic [1:0] {
        MSL_IDLE  = 2'b00,
        MSL_START = 2'b01,
        MSL_DATA  = 2'b10,
        MSL_STOP  = 2'b11
    } msl_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } msl_byte_s;
endpackage

// ---- design/msl_fifo.sv ----
// Small valid/ready FIFO
`timescale 1ns/10ps
module msl_fifo
    import msl_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             clr_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_reg;
    logic [AW:0]      rp_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_reg != rp_reg;
    assign out_data_o  = mem[rp_reg[AW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else if (clr_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wp_reg[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// ---- design/msl_link.sv ----
// Serial host link: fixed 8-N-1 receiver and transmitter with flow control
`timescale 1ns/10ps
module msl_link
    import msl_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Host pins
    input  wire logic       host_rx_i,
    input  wire logic       host_rts_i,
    output logic            host_tx_o,
    output logic            host_cts_o,
    output logic            service_req_n_o,
    // Command processor side
    input  wire logic       srq_pending_i,
    output msl_byte_s       rx_byte_o,
    input  wire logic       rx_ready_i,
    input  wire msl_byte_s  tx_byte_i,
    output logic            tx_ready_o,
    output logic            if_reset_o
);
    typedef struct packed {
        logic [1:0]  rx_sync;
        logic [1:0]  rts_sync;
        msl_state_e  rx_st;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        rx_push;
        logic [23:0] brk_cnt;
        logic        brk_hold;
        logic        if_rst;
        msl_state_e  tx_st;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [7:0]  tx_sh;
        logic        tx_line;
        logic        cts;
        logic        srq_n;
    } msl_link_s;

    msl_link_s  st_reg;
    msl_link_s  st_next;
    logic       rx_line;
    logic       rts_ok;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       fifo_pop;

    // Undo line inversion: a high pin is a logic zero
    assign rx_line = ~st_reg.rx_sync[1];
    assign rts_ok  = st_reg.rts_sync[1];

    msl_fifo #(
        .WIDTH (DATA_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .clr_i       (st_reg.if_rst),
        .in_valid_i  (st_reg.rx_push),
        .in_data_i   (st_reg.rx_sh),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );

    assign fifo_pop = fifo_out_valid & (~rx_byte_o.valid | rx_ready_i);

    always_comb begin
        st_next          = st_reg;
        st_next.rx_sync  = {st_reg.rx_sync[0], host_rx_i};
        st_next.rts_sync = {st_reg.rts_sync[0], host_rts_i};
        st_next.rx_push  = 1'b0;
        st_next.if_rst   = 1'b0;
        st_next.srq_n    = ~srq_pending_i;

        // CTS follows buffer space; a byte that meets a full buffer is dropped
        st_next.cts = fifo_in_ready;

        // Break: line held at logic zero well beyond one frame
        if (!rx_line) begin
            if (st_reg.brk_cnt != 24'(BREAK_CYC)) begin
                st_next.brk_cnt = st_reg.brk_cnt + 24'h000001;
            end else if (!st_reg.brk_hold) begin
                st_next.brk_hold = 1'b1;
                st_next.if_rst   = 1'b1;
            end
        end else begin
            st_next.brk_cnt  = BRK_ZERO;
            st_next.brk_hold = 1'b0;
        end

        case (st_reg.rx_st)
            MSL_IDLE: begin
                st_next.rx_cnt = CNT_ZERO;
                if (!rx_line && !st_reg.brk_hold) begin
                    st_next.rx_st = MSL_START;
                end
            end
            MSL_START: begin
                if (st_reg.rx_cnt == 16'(HALF_CYC)) begin
                    st_next.rx_cnt = CNT_ZERO;
                    st_next.rx_bit = BIT_ZERO;
                    st_next.rx_st  = rx_line ? MSL_IDLE : MSL_DATA;
                end else begin
                    st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
                end
            end
            MSL_DATA: begin
                if (st_reg.rx_cnt == 16'(BIT_CYC - 1)) begin
                    st_next.rx_cnt = CNT_ZERO;
                    st_next.rx_sh  = {rx_line, st_reg.rx_sh[7:1]};
                    st_next.rx_bit = st_reg.rx_bit + 4'h1;
                    if (st_reg.rx_bit == 4'(DATA_BITS - 1)) begin
                        st_next.rx_st = MSL_STOP;
                    end
                end else begin
                    st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
                end
            end
            MSL_STOP: begin
                if (st_reg.rx_cnt == 16'(BIT_CYC - 1)) begin
                    // Bad stop bit drops the character
                    st_next.rx_push = rx_line & fifo_in_ready;
                    st_next.rx_st   = MSL_IDLE;
                end else begin
                    st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
                end
            end
            default: st_next.rx_st = MSL_IDLE;
        endcase

        case (st_reg.tx_st)
            MSL_IDLE: begin
                st_next.tx_line = 1'b1;
                st_next.tx_cnt  = CNT_ZERO;
                if (tx_byte_i.valid && rts_ok) begin
                    st_next.tx_sh = tx_byte_i.data;
                    st_next.tx_st = MSL_START;
                    st_next.tx_line = 1'b0;
                end
            end
            MSL_START: begin
                if (st_reg.tx_cnt == 16'(BIT_CYC - 1)) begin
                    st_next.tx_cnt  = CNT_ZERO;
                    st_next.tx_bit  = BIT_ZERO;
                    st_next.tx_line = st_reg.tx_sh[0];
                    st_next.tx_st   = MSL_DATA;
                end else begin
                    st_next.tx_cnt = st_reg.tx_cnt + 16'h0001;
                end
            end
            MSL_DATA: begin
                if (st_reg.tx_cnt == 16'(BIT_CYC - 1)) begin
                    st_next.tx_cnt = CNT_ZERO;
                    st_next.tx_bit = st_reg.tx_bit + 4'h1;
                    st_next.tx_sh  = {1'b1, st_reg.tx_sh[7:1]};
                    st_next.tx_line = st_reg.tx_sh[1];
                    if (st_reg.tx_bit == 4'(DATA_BITS - 1)) begin
                        st_next.tx_line = 1'b1;
                        st_next.tx_st   = MSL_STOP;
                    end
                end else begin
                    st_next.tx_cnt = st_reg.tx_cnt + 16'h0001;
                end
            end
            MSL_STOP: begin
                // RTS is not looked at here: only a break cuts the frame short
                if (st_reg.tx_cnt == 16'(BIT_CYC - 1)) begin
                    st_next.tx_st = MSL_IDLE;
                end else begin
                    st_next.tx_cnt = st_reg.tx_cnt + 16'h0001;
                end
            end
            default: st_next.tx_st = MSL_IDLE;
        endcase

        // Break clears only the link state; frame format stays fixed
        if (st_reg.if_rst) begin
            st_next.rx_st   = MSL_IDLE;
            st_next.tx_st   = MSL_IDLE;
            st_next.tx_line = 1'b1;
            st_next.cts     = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg          <= '0;
            st_reg.rx_sync  <= SYNC_IDLE;
            st_reg.rx_st    <= MSL_IDLE;
            st_reg.tx_st    <= MSL_IDLE;
            st_reg.tx_line  <= 1'b1;
            st_reg.srq_n    <= 1'b1;
            rx_byte_o       <= '0;
        end else begin
            st_reg <= st_next;
            if (st_reg.if_rst) begin
                rx_byte_o.valid <= 1'b0;
            end else if (fifo_pop) begin
                rx_byte_o.valid <= 1'b1;
                rx_byte_o.data  <= fifo_out_data;
            end else if (rx_ready_i) begin
                rx_byte_o.valid <= 1'b0;
            end
        end
    end

    assign host_tx_o       = ~st_reg.tx_line;
    assign host_cts_o      = st_reg.cts;
    assign service_req_n_o = st_reg.srq_n;
    assign if_reset_o      = st_reg.if_rst;
    assign tx_ready_o      = 1'b0 | (st_reg.tx_st == MSL_IDLE && rts_ok && ~st_reg.if_rst);
endmodule

// ---- tb/msl_link_properties.sv ----
// Port assertions for the serial host link
`timescale 1ns/10ps
module msl_link_properties
    import msl_pkg::*;
(
    input wire logic      clock_i,
    input wire logic      rst_n_i,
    input wire logic      host_rx_i,
    input wire logic      host_rts_i,
    input wire logic      host_tx_o,
    input wire logic      host_cts_o,
    input wire logic      service_req_n_o,
    input wire logic      srq_pending_i,
    input wire msl_byte_s rx_byte_o,
    input wire logic      rx_ready_i,
    input wire msl_byte_s tx_byte_i,
    input wire logic      tx_ready_o,
    input wire logic      if_reset_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_srq_set: assert property (srq_pending_i |=> !service_req_n_o)
        else $error("service request not low");
    a_srq_clear: assert property (!srq_pending_i |=> service_req_n_o)
        else $error("service request not idle");
    a_tx_idle: assert property (tx_ready_o |-> !host_tx_o)
        else $error("idle line not low");
    a_start_high: assert property (tx_byte_i.valid && tx_ready_o |=> host_tx_o [*8])
        else $error("start bit not high");
    a_rts_hold: assert property (!host_rts_i [*3] |-> !tx_ready_o)
        else $error("byte taken without permission");
    a_break_pulse: assert property (if_reset_o |=> !if_reset_o)
        else $error("reset pulse too long");
    a_break_cts: assert property (if_reset_o |-> ##[0:2] !host_cts_o)
        else $error("no pause after break");
    a_rx_hold: assert property (rx_byte_o.valid && !rx_ready_i
        |=> rx_byte_o.valid && $stable(rx_byte_o.data))
        else $error("received byte not held");
endmodule

// ---- tb/msl_host_model.sv ----
// Host port model: inverted 8-N-1 sender, break source, frame decoder
`timescale 1ns/10ps
module msl_host_model
    import msl_pkg::*;
(
    // Clock and device pins
    input  wire logic  clock_i,
    input  wire logic  tx_line_i,
    input  wire logic  cts_i,
    output logic       rx_line_o,
    // Decoded device frames
    output logic       got_o,
    output logic [7:0] data_o,
    output logic       stop_ok_o
);
    initial begin
        rx_line_o = 1'b0;
        got_o = 1'b0;
        data_o = 8'h00;
        stop_ok_o = 1'b0;
    end

    task automatic bit_out(input logic b);
        #1 rx_line_o = ~b;
        repeat (BIT_CYC) @(posedge clock_i);
    endtask

    task automatic send(input logic [7:0] v, output logic ok);
        int n;
        n = 0;
        while (cts_i !== 1'b1 && n < 1000) begin
            @(posedge clock_i);
            n++;
        end
        ok = (n < 1000);
        bit_out(1'b0);
        for (int i = 0; i < DATA_BITS; i++) bit_out(v[i]);
        bit_out(1'b1);
    endtask

    task automatic brk();
        #1 rx_line_o = 1'b1;
        repeat (BIT_CYC * (BREAK_BITS + 5)) @(posedge clock_i);
        #1 rx_line_o = 1'b0;
    endtask

    // Mid-bit sampling; a device that aborts shows as high data bits
    always begin
        @(posedge tx_line_i);
        got_o = 1'b0;
        repeat (HALF_CYC) @(posedge clock_i);
        for (int i = 0; i < DATA_BITS; i++) begin
            repeat (BIT_CYC) @(posedge clock_i);
            data_o[i] = ~tx_line_i;
        end
        repeat (BIT_CYC) @(posedge clock_i);
        stop_ok_o = ~tx_line_i;
        got_o = 1'b1;
    end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial host link
`timescale 1ns/10ps
`define CMP(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t value differs", $time); end end
module tb_top;
    import msl_pkg::*;
    logic       clk, rst_n, rx_line, rts, tx_line, cts, srq_n, srq;
    logic       rx_rdy, tx_rdy, ifr, got, stop_ok, hi, ok;
    logic [7:0] gdat, d;
    msl_byte_s  rxb, txb;
    logic [7:0] exp_q[$];
    int         mismatches, cmp_count, resets, n;

    always #2.5 clk = ~clk;

    msl_link i_dut (.clock_i(clk), .rst_n_i(rst_n), .host_rx_i(rx_line), .host_rts_i(rts),
        .host_tx_o(tx_line), .host_cts_o(cts), .service_req_n_o(srq_n), .srq_pending_i(srq),
        .rx_byte_o(rxb), .rx_ready_i(rx_rdy), .tx_byte_i(txb), .tx_ready_o(tx_rdy),
        .if_reset_o(ifr));
    msl_host_model i_host (.clock_i(clk), .tx_line_i(tx_line), .cts_i(cts),
        .rx_line_o(rx_line), .got_o(got), .data_o(gdat), .stop_ok_o(stop_ok));

    task automatic stop_test();
        $display("compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] v);
        logic [7:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~v;
        `CMP(v, e)
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic send_tx(input logic [7:0] v);
        txb = '{1'b1, v};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_rdy !== 1'b1 && n < 100);
        #1 txb.valid = 1'b0;
        if (n >= 100) begin
            mismatches++;
            stop_test();
        end
    endtask

    task automatic drain();
        n = 0;
        while (exp_q.size() != 0 && n < BIT_CYC * 12) begin
            @(posedge clk);
            n++;
        end
        #1;
        if (exp_q.size() != 0) begin
            mismatches++;
            stop_test();
        end
    endtask

    always @(posedge got) begin
        chk(gdat);
        `CMP(stop_ok, 1'b1)
    end

    always @(posedge clk) begin
        if (rxb.valid === 1'b1 && rx_rdy === 1'b1) chk(rxb.data);
        if (ifr === 1'b1) resets++;
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        rts = 1'b0;
        srq = 1'b0;
        rx_rdy = 1'b1;
        txb = '0;
        d = 8'($urandom(67));
        step(5);
        rst_n = 1'b1;
        step(2);
        `CMP(cts, 1'b1)
        for (int i = 1; i >= 0; i--) begin
            srq = i[0];
            step(1);
            `CMP(srq_n, ~i[0])
        end
        $display("service request test done");
        rts = 1'b1;
        step(3);
        exp_q.push_back(d);
        send_tx(d);
        step(BIT_CYC * 3);
        rts = 1'b0;
        txb = '{1'b1, ~d};
        step(BIT_CYC * 13 / 2);
        hi = 1'b0;
        repeat (BIT_CYC * 2) begin
            @(posedge clk);
            hi = hi | tx_line;
        end
        `CMP(hi, 1'b0)
        `CMP(exp_q.size(), 0)
        #1 rts = 1'b1;
        exp_q.push_back(~d);
        send_tx(~d);
        drain();
        $display("transmit test done");
        d = 8'($urandom);
        exp_q.push_back(d);
        rx_rdy = 1'b0;
        i_host.send(d, ok);
        `CMP(ok, 1'b1)
        step(20);
        rx_rdy = 1'b1;
        drain();
        $display("receive test done");
        i_host.brk();
        step(10);
        `CMP(resets, 1)
        `CMP(cts, 1'b1)
        $display("break test done");
        stop_test();
    end
endmodule

bind msl_link msl_link_properties i_props (.*);
